// file: shared/ptc_pkg.sv
package ptc_pkg;

	// ---------------------------------------------------------------
	// command block layout (word index within the block)
	// ---------------------------------------------------------------
	localparam int BLK_WORDS = 16;
	localparam logic [3:0] OFS_ERR = 4'h0;
	localparam logic [3:0] OFS_CODE = 4'h1;
	localparam logic [3:0] OFS_CONN = 4'h2;
	localparam logic [3:0] OFS_PROTO = 4'h3;
	localparam logic [3:0] OFS_PORT = 4'h4;
	localparam logic [3:0] OFS_BAUD = 4'h5;
	localparam logic [3:0] OFS_BITS = 4'h6;
	localparam logic [3:0] OFS_PAR = 4'h7;
	localparam logic [3:0] OFS_STOP = 4'h8;
	localparam logic [3:0] OFS_HS = 4'h9;
	localparam logic [3:0] OFS_OPT = 4'hA;
	localparam logic [3:0] OFS_MTAB = 4'hB;
	localparam logic [3:0] OFS_WSRC = 4'h3;
	localparam logic [3:0] OFS_WCNT = 4'h4;
	localparam logic [3:0] OFS_WDST = 4'h5;
	localparam logic [3:0] OFS_TMO = 4'h6;
	localparam logic [3:0] OFS_RSRC = 4'h7;
	localparam logic [3:0] OFS_RCNT = 4'h8;
	localparam logic [3:0] OFS_RDST = 4'h9;

	// ---------------------------------------------------------------
	// command codes and field values
	// ---------------------------------------------------------------
	localparam logic [15:0] CMD_OPEN = 16'h0001;
	localparam logic [15:0] CMD_CLOSE = 16'h0002;
	localparam logic [15:0] CMD_WRITE = 16'h0201;
	localparam logic [15:0] CMD_READ = 16'h0202;
	localparam logic [15:0] CMD_XCHG = 16'h0203;
	localparam logic [15:0] PROTO_PEER = 16'h0024;
	localparam logic [15:0] CONN_MIN = 16'h4B15;
	localparam logic [15:0] CONN_MAX = 16'h4B63;
	localparam logic [15:0] PORT_MIN = 16'h0001;
	localparam logic [15:0] PORT_MAX = 16'h0004;
	localparam logic [15:0] HS_NONE = 16'h0000;
	localparam logic [15:0] HS_SOFT = 16'h0001;
	localparam logic [15:0] HS_HARD = 16'h0002;
	localparam logic [15:0] HS_MODEM = 16'h0006;
	localparam logic [15:0] OPT_MODEM = 16'h0001;
	localparam logic [15:0] PAR_MAX = 16'h0002;
	localparam logic [15:0] WCNT_MAX = 16'h00FE;
	localparam logic [15:0] CNT_MAX = 16'h0100;
	localparam logic [15:0] TMO_DEFAULT_S = 16'h0009;
	localparam logic [15:0] TMO_INFINITE = 16'h03E7;

	// ---------------------------------------------------------------
	// error codes written into the error word
	// ---------------------------------------------------------------
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] ERR_CODE = 16'h0001;
	localparam logic [15:0] ERR_CONN = 16'h0002;
	localparam logic [15:0] ERR_PROTO = 16'h0003;
	localparam logic [15:0] ERR_PORT = 16'h0004;
	localparam logic [15:0] ERR_PARAM = 16'h0005;
	localparam logic [15:0] ERR_COUNT = 16'h0006;
	localparam logic [15:0] ERR_TIMEOUT = 16'h0007;
	localparam logic [15:0] ERR_REMOTE = 16'h0008;

	// ---------------------------------------------------------------
	// register byte addresses and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h40;
	localparam logic [7:0] ADR_IST = 8'h44;
	localparam logic [7:0] ADR_IMSK = 8'h48;
	localparam logic [7:0] ADR_PSEL = 8'h4C;
	localparam logic [7:0] ADR_PSTAT = 8'h50;
	localparam logic [1:0] IMSK_RST = 2'h0;
	localparam logic [3:0] PSEL_RST = 4'h0;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ = 32'h017D_7840;
	localparam int unsigned TICK_S = 32'h0000_0001;
	localparam int unsigned TICK_CYC = CLK_HZ * TICK_S;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_CHECK = 4'h1,
		ST_HDR = 4'h2,
		ST_FETCH = 4'h3,
		ST_SEND = 4'h4,
		ST_WAIT = 4'h5,
		ST_RECV = 4'h6,
		ST_STORE = 4'h7,
		ST_DONE = 4'h8
	} ptc_state_t;

endpackage

// file: verilog/ptc_cmd_block.sv
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01: code 1 opens a connection, starting a protocol instance on the chosen port.
// RULE_02: host supplies an unused connection number 19221 to 19299 when opening.
// RULE_03: protocol type word must be 36 to select the peer module protocol.
// RULE_04: port 1 to 4, one connection per port, port must be logic selected.
// RULE_05: baud, width, parity and stop from the block override switch settings.
// RULE_06: host asks for 7 bits, odd parity, one stop; parity 0/1/2 none/odd/even.
// RULE_07: pacing word: 0 none, 1 software, 2 hardware, 6 modem rts/cts.
// RULE_08: with modem pacing, raise rts while sending and wait for cts.
// RULE_09: option bit 0x0001 enables modem control, word 11 locates its table.
// RULE_10: host zeroes the unused trailing words of each block.
// RULE_11: host clears the error word; device writes a code there on failure.
// RULE_12: code 2 closes a connection, freeing its port and number for reuse.
// RULE_13: later commands name the instance by connection number, not port.
// RULE_14: write 513 and read 514 carry source, count 1-256, destination, timeout.
// RULE_15: code 515 writes a local block then reads a remote block, one transaction.
// RULE_16: exchange layout: write at 3/4/5, counts 1-254 and 1-256, read at 7/8/9.
// RULE_17: exchange checks the response and stores read data only when error-free.
// RULE_18: timeout in seconds; zero means about 9, 999 means wait forever.
// RULE_19: unknown code, bad connection, busy port or bad count gives an error code.
module ptc_cmd_block import ptc_pkg::*; #(
	parameter int unsigned CYC_PER_SEC = TICK_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	output logic tx_valid_o,
	output logic [15:0] tx_data_o,
	output logic [1:0] tx_port_o,
	input wire logic tx_ready_i,
	input wire logic rx_valid_i,
	input wire logic [15:0] rx_data_i,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [15:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	input wire logic [15:0] mem_rdata_i,
	input wire logic mem_ack_i,
	input wire logic [3:0] cts_i,
	output logic [3:0] rts_o,
	output logic [3:0] port_open_o,
	output logic [63:0] port_baud_o,
	output logic [3:0] port_char8_o,
	output logic [7:0] port_parity_o,
	output logic [3:0] port_stop2_o,
	output logic [11:0] port_pacing_o,
	output logic [3:0] port_modem_o,
	output logic [63:0] port_modem_tab_o
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [2:0] find_port(input logic [15:0] c, input logic [3:0][15:0] tab,
		input logic [3:0] opn);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < 4; i++) begin
			if (opn[i] && tab[i] == c) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic baud_ok(input logic [15:0] b);
		return b == 16'h012C || b == 16'h0258 || b == 16'h04B0 || b == 16'h0960 ||
			b == 16'h12C0 || b == 16'h2580 || b == 16'h4B00;
	endfunction

	function automatic logic cnt_ok(input logic [15:0] n, input logic [15:0] max);
		return n != 16'h0000 && n <= max;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [15:0] blk_reg [BLK_WORDS];
	logic ack_reg;
	logic [31:0] dat_reg;
	logic [1:0] ist_reg;
	logic [1:0] imsk_reg;
	logic [3:0] psel_reg;
	logic irq_reg;
	ptc_state_t state_reg;
	logic [15:0] code_reg;
	logic [15:0] err_reg;
	logic [1:0] pidx_reg;
	logic [2:0] hidx_reg;
	logic [8:0] wcnt_reg;
	logic [8:0] rcnt_reg;
	logic [8:0] cnt_reg;
	logic [15:0] laddr_reg;
	logic [15:0] ldst_reg;
	logic [15:0] tmo_reg;
	logic tmo_inf_reg;
	logic [31:0] div_reg;
	logic [3:0] open_reg;
	logic [3:0][15:0] conn_reg;
	logic [3:0][15:0] baud_reg;
	logic [3:0] char8_reg;
	logic [3:0][1:0] par_reg;
	logic [3:0] stop2_reg;
	logic [3:0][2:0] hs_reg;
	logic [3:0] modem_reg;
	logic [3:0][15:0] mtab_reg;
	logic [3:0] cts_meta_reg;
	logic [3:0] cts_sync_reg;
	logic [3:0] rts_reg;
	logic tx_valid_reg;
	logic [15:0] tx_data_reg;
	logic mem_req_reg;
	logic mem_we_reg;
	logic [15:0] mem_addr_reg;
	logic [15:0] mem_wdata_reg;

	logic acc;
	logic wr_en;
	logic go;
	logic [31:0] rd_data;
	logic [15:0] chk_err;
	logic [2:0] hit;
	logic [1:0] new_port;
	logic sec_tick;
	logic timed_out;
	logic paced;
	logic tx_clear;
	logic [15:0] hdr_word;

	assign acc = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr_en = acc && wb_we_i;
	assign go = wr_en && wb_adr_i == ADR_CTRL && wb_sel_i[0] && wb_dat_i[0] && state_reg == ST_IDLE;
	assign new_port = 2'(blk_reg[OFS_PORT][1:0] - 2'h1);
	assign sec_tick = div_reg == CYC_PER_SEC - 1;
	assign timed_out = !tmo_inf_reg && tmo_reg == 16'h0000;
	// rts/cts pacing holds off the header and data words, never the memory fetches
	assign paced = hs_reg[pidx_reg] == HS_MODEM[2:0];
	assign tx_clear = !paced || cts_sync_reg[pidx_reg];

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	always_comb begin
		rd_data = 32'h0000_0000;
		if (wb_adr_i[7:6] == 2'h0) begin
			rd_data = {16'h0000, blk_reg[wb_adr_i[5:2]]};
		end else begin
			case (wb_adr_i)
				ADR_CTRL: rd_data = {31'h0000_0000, state_reg != ST_IDLE};
				ADR_IST: rd_data = {30'h0000_0000, ist_reg};
				ADR_IMSK: rd_data = {30'h0000_0000, imsk_reg};
				ADR_PSEL: rd_data = {28'h000_0000, psel_reg};
				ADR_PSTAT: rd_data = {28'h000_0000, open_reg};
				default: rd_data = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= acc;
			if (acc) begin
				dat_reg <= rd_data;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			imsk_reg <= IMSK_RST;
			psel_reg <= PSEL_RST;
		end else if (wr_en && wb_sel_i[0]) begin
			if (wb_adr_i == ADR_IMSK) begin
				imsk_reg <= wb_dat_i[1:0];
			end
			if (wb_adr_i == ADR_PSEL) begin
				psel_reg <= wb_dat_i[3:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// command block memory
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < BLK_WORDS; i++) begin
				blk_reg[i] <= 16'h0000;
			end
		end else begin
			if (wr_en && wb_adr_i[7:6] == 2'h0) begin
				blk_reg[wb_adr_i[5:2]] <= merge(blk_reg[wb_adr_i[5:2]], wb_dat_i, wb_sel_i);
			end
			// RULE_11: error word report
			// the device write lands last, so a host clear in the same cycle loses
			if (state_reg == ST_DONE && err_reg != ERR_NONE) begin
				blk_reg[OFS_ERR] <= err_reg;
			end
		end
	end

	// ---------------------------------------------------------------
	// interrupts
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ist_reg <= 2'h0;
			irq_reg <= 1'b0;
		end else begin
			ist_reg <= (ist_reg & ~((wr_en && wb_adr_i == ADR_IST && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0)) |
				((state_reg == ST_DONE) ? {err_reg != ERR_NONE, 1'b1} : 2'h0);
			irq_reg <= |(ist_reg & imsk_reg);
		end
	end

	// ---------------------------------------------------------------
	// command validation
	// ---------------------------------------------------------------
	always_comb begin
		chk_err = ERR_NONE;
		hit = find_port(blk_reg[OFS_CONN], conn_reg, open_reg);
		case (blk_reg[OFS_CODE])
			CMD_OPEN: begin
				// RULE_02: connection number range and reuse
				if (blk_reg[OFS_CONN] < CONN_MIN || blk_reg[OFS_CONN] > CONN_MAX || hit[2]) begin
					chk_err = ERR_CONN;
				// RULE_03: protocol type check
				end else if (blk_reg[OFS_PROTO] != PROTO_PEER) begin
					chk_err = ERR_PROTO;
				// RULE_04: one connection per selectable port
				end else if (blk_reg[OFS_PORT] < PORT_MIN || blk_reg[OFS_PORT] > PORT_MAX ||
					open_reg[new_port] || !psel_reg[new_port]) begin
					chk_err = ERR_PORT;
				// RULE_07: line and pacing values
				end else if (!baud_ok(blk_reg[OFS_BAUD]) ||
					(blk_reg[OFS_BITS] != 16'h0007 && blk_reg[OFS_BITS] != 16'h0008) ||
					blk_reg[OFS_PAR] > PAR_MAX ||
					(blk_reg[OFS_STOP] != 16'h0001 && blk_reg[OFS_STOP] != 16'h0002) ||
					(blk_reg[OFS_HS] != HS_NONE && blk_reg[OFS_HS] != HS_SOFT &&
					blk_reg[OFS_HS] != HS_HARD && blk_reg[OFS_HS] != HS_MODEM) ||
					(blk_reg[OFS_OPT] & ~OPT_MODEM) != 16'h0000) begin
					chk_err = ERR_PARAM;
				end
			end
			CMD_CLOSE: begin
				if (!hit[2]) begin
					chk_err = ERR_CONN;
				end
			end
			// RULE_13: transfers address the instance by connection number
			CMD_WRITE, CMD_READ: begin
				if (!hit[2]) begin
					chk_err = ERR_CONN;
				// RULE_14: transfer count range
				end else if (!cnt_ok(blk_reg[OFS_WCNT], CNT_MAX)) begin
					chk_err = ERR_COUNT;
				end
			end
			CMD_XCHG: begin
				if (!hit[2]) begin
					chk_err = ERR_CONN;
				// RULE_16: exchange count ranges
				end else if (!cnt_ok(blk_reg[OFS_WCNT], WCNT_MAX) || !cnt_ok(blk_reg[OFS_RCNT], CNT_MAX)) begin
					chk_err = ERR_COUNT;
				end
			end
			// RULE_19: unknown command
			default: chk_err = ERR_CODE;
		endcase
	end

	// header: code, write count, word 5 destination, read count, then word 7 on exchange or word 3 otherwise
	always_comb begin
		case (hidx_reg)
			3'h0: hdr_word = code_reg;
			3'h1: hdr_word = {7'h00, wcnt_reg};
			3'h2: hdr_word = blk_reg[OFS_WDST];
			3'h3: hdr_word = {7'h00, rcnt_reg};
			default: hdr_word = (code_reg == CMD_XCHG) ? blk_reg[OFS_RSRC] : blk_reg[OFS_WSRC];
		endcase
	end

	// ---------------------------------------------------------------
	// per-port connection table
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			open_reg <= 4'h0;
			conn_reg <= '0;
			baud_reg <= '0;
			char8_reg <= 4'h0;
			par_reg <= '0;
			stop2_reg <= 4'h0;
			hs_reg <= '0;
			modem_reg <= 4'h0;
			mtab_reg <= '0;
		end else if (state_reg == ST_CHECK && chk_err == ERR_NONE) begin
			// RULE_01: open binds an instance to the port
			if (code_reg == CMD_OPEN) begin
				open_reg[new_port] <= 1'b1;
				conn_reg[new_port] <= blk_reg[OFS_CONN];
				// RULE_05: block settings override switches
				baud_reg[new_port] <= blk_reg[OFS_BAUD];
				char8_reg[new_port] <= blk_reg[OFS_BITS] == 16'h0008;
				// RULE_06: parity encoding kept as given
				par_reg[new_port] <= blk_reg[OFS_PAR][1:0];
				stop2_reg[new_port] <= blk_reg[OFS_STOP] == 16'h0002;
				hs_reg[new_port] <= blk_reg[OFS_HS][2:0];
				// RULE_09: modem option and table pointer
				modem_reg[new_port] <= blk_reg[OFS_OPT][0];
				mtab_reg[new_port] <= blk_reg[OFS_MTAB];
			end
			// RULE_12: close frees port and number
			if (code_reg == CMD_CLOSE) begin
				open_reg[hit[1:0]] <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// timeout seconds
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || state_reg == ST_CHECK) begin
			div_reg <= 32'h0000_0000;
		end else begin
			div_reg <= sec_tick ? 32'h0000_0000 : div_reg + 32'h0000_0001;
		end
	end

	// ---------------------------------------------------------------
	// cts synchronisers
	// ---------------------------------------------------------------
	generate
		for (genvar g = 0; g < 4; g++) begin : g_cts
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cts_meta_reg[g] <= 1'b0;
					cts_sync_reg[g] <= 1'b0;
				end else begin
					cts_meta_reg[g] <= cts_i[g];
					cts_sync_reg[g] <= cts_meta_reg[g];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// command sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			code_reg <= 16'h0000;
			err_reg <= ERR_NONE;
			pidx_reg <= 2'h0;
			hidx_reg <= 3'h0;
			wcnt_reg <= 9'h000;
			rcnt_reg <= 9'h000;
			cnt_reg <= 9'h000;
			laddr_reg <= 16'h0000;
			ldst_reg <= 16'h0000;
			tmo_reg <= 16'h0000;
			tmo_inf_reg <= 1'b0;
			rts_reg <= 4'h0;
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 16'h0000;
			mem_req_reg <= 1'b0;
			mem_we_reg <= 1'b0;
			mem_addr_reg <= 16'h0000;
			mem_wdata_reg <= 16'h0000;
		end else begin
			if ((state_reg == ST_WAIT || state_reg == ST_RECV) && sec_tick && !timed_out && !tmo_inf_reg) begin
				tmo_reg <= tmo_reg - 16'h0001;
			end
			unique case (state_reg)
				ST_IDLE: begin
					err_reg <= ERR_NONE;
					if (go) begin
						code_reg <= blk_reg[OFS_CODE];
						state_reg <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					err_reg <= chk_err;
					pidx_reg <= hit[1:0];
					hidx_reg <= 3'h0;
					cnt_reg <= 9'h000;
					// RULE_18: zero is default, 999 never expires
					tmo_reg <= (blk_reg[OFS_TMO] == 16'h0000) ? TMO_DEFAULT_S : blk_reg[OFS_TMO];
					tmo_inf_reg <= blk_reg[OFS_TMO] >= TMO_INFINITE;
					wcnt_reg <= (code_reg == CMD_READ) ? 9'h000 : blk_reg[OFS_WCNT][8:0];
					// RULE_15: exchange takes both counts
					rcnt_reg <= (code_reg == CMD_XCHG) ? blk_reg[OFS_RCNT][8:0] :
						(code_reg == CMD_READ) ? blk_reg[OFS_WCNT][8:0] : 9'h000;
					laddr_reg <= blk_reg[OFS_WSRC];
					ldst_reg <= (code_reg == CMD_XCHG) ? blk_reg[OFS_RDST] : blk_reg[OFS_WDST];
					if (chk_err != ERR_NONE || code_reg == CMD_OPEN || code_reg == CMD_CLOSE) begin
						state_reg <= ST_DONE;
					end else begin
						state_reg <= ST_HDR;
					end
				end
				ST_HDR, ST_SEND: begin
					// RULE_08: rts up while sending, data waits for cts
					rts_reg <= paced ? 4'h1 << pidx_reg : 4'h0;
					if (tx_valid_reg && tx_ready_i) begin
						tx_valid_reg <= 1'b0;
						if (state_reg == ST_HDR && hidx_reg != 3'h4) begin
							hidx_reg <= hidx_reg + 3'h1;
						end else if (state_reg == ST_HDR) begin
							state_reg <= (wcnt_reg != 9'h000) ? ST_FETCH : ST_WAIT;
						end else begin
							cnt_reg <= cnt_reg + 9'h001;
							laddr_reg <= laddr_reg + 16'h0001;
							state_reg <= (cnt_reg == wcnt_reg - 9'h001) ? ST_WAIT : ST_FETCH;
						end
					end else if (!tx_valid_reg && tx_clear) begin
						tx_valid_reg <= 1'b1;
						tx_data_reg <= (state_reg == ST_HDR) ? hdr_word : mem_wdata_reg;
					end
				end
				ST_FETCH: begin
					mem_req_reg <= !mem_ack_i;
					mem_we_reg <= 1'b0;
					mem_addr_reg <= laddr_reg;
					if (mem_req_reg && mem_ack_i) begin
						mem_wdata_reg <= mem_rdata_i;
						state_reg <= ST_SEND;
					end
				end
				ST_WAIT, ST_RECV: begin
					rts_reg <= 4'h0;
					cnt_reg <= (state_reg == ST_WAIT) ? 9'h000 : cnt_reg;
					// RULE_17: remote status first, store only when clean
					if (rx_valid_i && state_reg == ST_WAIT) begin
						err_reg <= (rx_data_i != 16'h0000) ? ERR_REMOTE : ERR_NONE;
						state_reg <= (rx_data_i != 16'h0000 || rcnt_reg == 9'h000) ? ST_DONE : ST_RECV;
					end else if (rx_valid_i) begin
						mem_req_reg <= 1'b1;
						mem_we_reg <= 1'b1;
						mem_addr_reg <= ldst_reg;
						mem_wdata_reg <= rx_data_i;
						state_reg <= ST_STORE;
					end else if (timed_out) begin
						err_reg <= ERR_TIMEOUT;
						state_reg <= ST_DONE;
					end
				end
				ST_STORE: begin
					if (mem_ack_i) begin
						mem_req_reg <= 1'b0;
						mem_we_reg <= 1'b0;
						cnt_reg <= cnt_reg + 9'h001;
						ldst_reg <= ldst_reg + 16'h0001;
						state_reg <= (cnt_reg == rcnt_reg - 9'h001) ? ST_DONE : ST_RECV;
					end
				end
				ST_DONE: begin
					rts_reg <= 4'h0;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign irq_o = irq_reg;
	assign tx_valid_o = tx_valid_reg;
	assign tx_data_o = tx_data_reg;
	assign tx_port_o = pidx_reg;
	assign mem_req_o = mem_req_reg;
	assign mem_we_o = mem_we_reg;
	assign mem_addr_o = mem_addr_reg;
	assign mem_wdata_o = mem_wdata_reg;
	assign rts_o = rts_reg;
	assign port_open_o = open_reg;
	assign port_baud_o = baud_reg;
	assign port_char8_o = char8_reg;
	assign port_parity_o = par_reg;
	assign port_stop2_o = stop2_reg;
	assign port_pacing_o = hs_reg;
	assign port_modem_o = modem_reg;
	assign port_modem_tab_o = mtab_reg;

endmodule // ptc_cmd_block

// file: verification/ptc_cmd_block_monitor.sv
`timescale 1ns/1ns
module ptc_cmd_block_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic irq_o,
	input wire logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic [15:0] tx_data_o,
	input wire logic [1:0] tx_port_o,
	input wire logic mem_req_o,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_addr_o,
	input wire logic [3:0] rts_o,
	input wire logic [3:0] cts_i,
	input wire logic [11:0] port_pacing_o,
	input wire logic [3:0] port_open_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack not in next cycle");
	property p_ack_cause; wb_ack_o |-> $past(wb_stb_i); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_tx_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("link word dropped before accept");
	property p_mem_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o); endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped early");
	property p_rts; tx_valid_o && tx_port_o == 2'h0 && port_pacing_o[2:0] == 3'h6 |-> rts_o[0]; endproperty
	a_rts: assert property (p_rts) else $error("sending without rts");
	property p_cts; $rose(tx_valid_o) && tx_port_o == 2'h0 && port_pacing_o[2:0] == 3'h6 |-> $past(cts_i[0], 2); endproperty
	a_cts: assert property (p_cts) else $error("sending before cts");
	property p_rst; $fell(rst_i) |-> !tx_valid_o && !irq_o && port_open_o == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule // ptc_cmd_block_monitor
bind ptc_cmd_block ptc_cmd_block_monitor mon_u (.*);

// file: verification/ptc_link_model.sv
`timescale 1ns/1ns
module ptc_link_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tx_valid_i,
	input wire logic [15:0] tx_data_i,
	output logic tx_ready_o,
	output logic rx_valid_o,
	output logic [15:0] rx_data_o,
	input wire logic mem_req_i,
	input wire logic mem_we_i,
	input wire logic [15:0] mem_addr_i,
	input wire logic [15:0] mem_wdata_i,
	output logic [15:0] mem_rdata_o,
	output logic mem_ack_o,
	input wire logic [3:0] rts_i,
	output logic [3:0] cts_o
);
	logic [15:0] mem [256];
	logic [15:0] wd;
	logic [8:0] n, wc, rc, k;
	logic busy;
	initial for (int i = 0; i < 256; i++) mem[i] = 16'h5A00 | 16'(i);
	always @(posedge clk_i) begin
		// ready stalls every other cycle
		tx_ready_o <= ~tx_ready_o & ~rst_i;
		cts_o <= rts_i;
		mem_ack_o <= mem_req_i & ~mem_ack_o;
		mem_rdata_o <= mem[mem_addr_i[7:0]];
		if (mem_req_i & mem_we_i & ~mem_ack_o) mem[mem_addr_i[7:0]] <= mem_wdata_i;
		rx_valid_o <= 1'b0;
		rx_data_o <= ~rx_data_o;
		if (rst_i) begin
			n <= 9'h000;
			busy <= 1'b0;
		end else if (busy) begin
			if (tx_ready_o & ~mem_req_i) begin
				rx_valid_o <= 1'b1;
				rx_data_o <= (k == 9'h000) ? 16'h0000 : 16'hA5A0 + 16'(k);
				k <= k + 9'h001;
				if (k == rc) busy <= 1'b0;
			end
		end else if (tx_valid_i & tx_ready_o) begin
			n <= n + 9'h001;
			if (n == 9'h001) wc <= tx_data_i[8:0];
			if (n == 9'h003) rc <= tx_data_i[8:0];
			if (n > 9'h004) wd <= tx_data_i;
			if (n > 9'h004 && n == 9'h004 + wc) begin
				busy <= 1'b1;
				k <= 9'h000;
				n <= 9'h000;
			end
		end
	end
endmodule // ptc_link_model

// file: verification/test_peer_transfer_command_block.sv
`timescale 1ns/1ns
module test_peer_transfer_command_block;
	import ptc_pkg::*;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq_o, tx_valid_o, tx_ready_i;
	logic rx_valid_i, mem_req_o, mem_we_o, mem_ack_i;
	logic [1:0] tx_port_o;
	logic [3:0] wb_sel_i = 0, cts_i, rts_o, port_open_o, port_char8_o, port_stop2_o, port_modem_o;
	logic [7:0] wb_adr_i = 0, port_parity_o;
	logic [11:0] port_pacing_o;
	logic [15:0] tx_data_o, rx_data_i, mem_addr_o, mem_wdata_o, mem_rdata_i;
	logic [15:0] blk [16];
	logic [31:0] wb_dat_i = 0, wb_dat_o, q;
	logic [63:0] port_baud_o, port_modem_tab_o;
	int miscompares = 0, n_compared = 0;
	always #20 clk_i = ~clk_i;
	ptc_cmd_block #(.CYC_PER_SEC(20)) dut_u (.*);
	ptc_link_model model_u (.clk_i, .rst_i, .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i),
		.rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
		.mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i),
		.rts_i(rts_o), .cts_o(cts_i));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'h3};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic set(input logic [15:0] c, n, w3, w4, w5, w6, w7, w8, w9);
		blk = '{16'h0000, c, n, w3, w4, w5, w6, w7, w8, w9, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	endtask
	task automatic run(input logic [15:0] exp);
		for (int i = 0; i < 16; i++) wb(1'b1, 8'(i * 4), {16'h0000, blk[i]}, q);
		wb(1'b1, ADR_CTRL, 32'h0000_0001, q);
		do wb(1'b0, ADR_CTRL, 32'h0000_0000, q); while (q[0] !== 1'b0);
		wb(1'b0, 8'h00, 32'h0000_0000, q);
		cmp(q, {16'h0000, exp});
		$display("command %h done, error word %h", blk[1], q[15:0]);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#(40 * 20000);
		miscompares++;
		wrap_up;
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		wb(1'b0, ADR_IMSK, 32'h0000_0000, q); cmp(q, 32'h0000_0000);
		wb(1'b0, ADR_PSEL, 32'h0000_0000, q); cmp(q, 32'h0000_0000);
		wb(1'b0, 8'hFC, 32'h0000_0000, q); cmp(q, 32'h0000_0000);
		set(CMD_OPEN, CONN_MIN, PROTO_PEER, 16'h0001, 16'h2580, 16'h0007, 16'h0001, 16'h0001, HS_MODEM);
		run(ERR_PORT);
		wb(1'b1, ADR_PSEL, 32'h0000_0001, q);
		wb(1'b1, ADR_IST, 32'h0000_0003, q);
		wb(1'b1, ADR_IMSK, 32'h0000_0003, q);
		cmp(irq_o, 32'h0000_0000);
		blk[3] = 16'h0023;
		run(ERR_PROTO);
		cmp(irq_o, 32'h0000_0001);
		wb(1'b1, ADR_IST, 32'h0000_0003, q);
		wb(1'b0, ADR_IST, 32'h0000_0000, q); cmp(irq_o, 32'h0000_0000);
		blk[3] = PROTO_PEER;
		run(ERR_NONE);
		wb(1'b0, ADR_PSTAT, 32'h0000_0000, q); cmp(q, 32'h0000_0001);
		cmp(port_pacing_o[2:0], 32'h0000_0006);
		cmp(port_baud_o[15:0], 32'h0000_2580);
		cmp({port_char8_o, port_parity_o, port_stop2_o, port_modem_o}, 32'h0000_0100);
		blk[2] = CONN_MIN + 16'h0001;
		run(ERR_PORT);
		wb(1'b1, ADR_IMSK, 32'h0000_0000, q);
		blk[1] = 16'h0007;
		run(ERR_CODE);
		cmp(irq_o, 32'h0000_0000);
		set(CMD_XCHG, CONN_MIN, 16'h0010, 16'h0001, 16'h0200, 16'h0000, 16'h0300, 16'h0002, 16'h0030);
		run(ERR_NONE);
		cmp(model_u.wd, 32'h0000_5A10);
		cmp(model_u.mem[8'h31], 32'h0000_A5A2);
		blk[4] = 16'h00FF;
		run(ERR_COUNT);
		set(CMD_WRITE, CONN_MIN - 16'h0001, 16'h0010, 16'h0001, 16'h0200, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		run(ERR_CONN);
		set(CMD_CLOSE, CONN_MIN, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		run(ERR_NONE);
		wb(1'b0, ADR_PSTAT, 32'h0000_0000, q); cmp(q, 32'h0000_0000);
		set(CMD_OPEN, CONN_MIN, PROTO_PEER, 16'h0001, 16'h2580, 16'h0007, 16'h0001, 16'h0001, HS_NONE);
		run(ERR_NONE);
		wrap_up;
	end
endmodule // test_peer_transfer_command_block
